// ### core/ascp_defines.svh
`ifndef ASCP_DEFINES_SVH
`define ASCP_DEFINES_SVH

// Instruction byte field positions.
`define ASCP_INS_DIR_BIT 7
`define ASCP_INS_CNT_HI 6
`define ASCP_INS_CNT_LO 5
`define ASCP_INS_FSC_BIT 4
`define ASCP_INS_REG_HI 3
`define ASCP_INS_REG_LO 2
`define ASCP_INS_BYTE_HI 1
`define ASCP_INS_BYTE_LO 0

// Control register field positions used by the port itself.
`define ASCP_CTRL_LINE_USAGE 0
`define ASCP_CTRL_BIT_ORDER 1
`define ASCP_CTRL_BYTE_ORDER 2

// Reset values of the writable registers and of the result register.
`define ASCP_CTRL_RESET 24'h00_0100
`define ASCP_CAL_RESET 24'h00_0000
`define ASCP_RESULT_RESET 24'h00_0000

// Register select codes.
`define ASCP_SEL_RESULT 2'h0
`define ASCP_SEL_CTRL 2'h1
`define ASCP_SEL_OFFSET 2'h2
`define ASCP_SEL_FULLSCALE 2'h3

// Starting byte code that addresses nothing.
`define ASCP_BYTE_NONE 2'h3

// Bits per serial byte, as the last bit index.
`define ASCP_LAST_BIT 3'h7

// Value driven for bytes that address no register.
`define ASCP_UNDEF_BYTE 8'h00

// Number of pin inputs passed through the synchroniser.
`define ASCP_SYNC_W 3

`endif

// ### core/ascp_pkg.sv
package ascp_pkg;

	// Phase of a communication cycle.
	typedef enum logic [0:0] {
		ASCP_INSTR,
		ASCP_DATA
	} ascp_phase_t;

	// Index of a pin input within the synchroniser bus.
	typedef enum int {
		ASCP_PIN_SCLK = 0,
		ASCP_PIN_CS_N = 1,
		ASCP_PIN_SDIO = 2
	} ascp_pin_t;

endpackage

// ### core/ascp_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
`include "ascp_defines.svh"

// Brings the serial pins into the sys_clk domain and finds serial clock edges.
module ascp_pin_sync (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Raw pins.
	input wire logic [`ASCP_SYNC_W-1:0] pins_raw,
	// Synchronised levels and serial clock edge pulses.
	output logic [`ASCP_SYNC_W-1:0] pins_sync,
	output logic sclk_rise,
	output logic sclk_fall
);

	// First stage, read only by the second stage.
	logic [`ASCP_SYNC_W-1:0] meta;
	// Previous synchronised serial clock, for edge finding.
	logic sclk_prev;

	// Two flip-flops per pin; chip select idles high so it resets high.
	genvar g;
	generate
		for (g = 0; g < `ASCP_SYNC_W; g = g + 1) begin : g_sync
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					meta[g] <= (g == ascp_pkg::ASCP_PIN_CS_N);
					pins_sync[g] <= (g == ascp_pkg::ASCP_PIN_CS_N);
				end else begin
					meta[g] <= pins_raw[g];
					pins_sync[g] <= meta[g];
				end
			end
		end
	endgenerate

	// Edge detector looks only at the second stage.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sclk_prev <= 1'b0;
		end else begin
			sclk_prev <= pins_sync[ascp_pkg::ASCP_PIN_SCLK];
		end
	end

	assign sclk_rise = pins_sync[ascp_pkg::ASCP_PIN_SCLK] & ~sclk_prev;
	assign sclk_fall = ~pins_sync[ascp_pkg::ASCP_PIN_SCLK] & sclk_prev;

endmodule // ascp_pin_sync

`default_nettype wire

// ### core/ascp_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "ascp_defines.svh"

// Overview of operation
// - Data phase follows the stored instruction.
// - Instruction bit seven: zero read, one write.
// - Bits six, five give one to four bytes.
// - Bit four picks positive or negative calibration.
// - Bits three, two register; one, zero start.
// - Select codes map result, control, offset, fullscale.
// - Writes never touch the conversion result.
// - All write data enters on data line.
// - Incoming bits captured on serial clock rise.
// - All five registers are readable.
// - Three-wire reads drive the separate output.
// - Two-wire reads drive the shared data line.
// - Read bits launched on falling edge.
// - Result holds 24 bits, read-only, byte two top.
// - Control bit zero selects line usage.
// - Control bit one selects bit order.
// - Control bit two selects byte stepping direction.
// - Select high suspends cycle until reasserted.
module ascp_port (
	// System clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Serial pins from the host.
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdio_in,
	// Serial pins to the host.
	output logic sdio_out,
	output logic sdio_oe,
	output logic separate_output_line,
	output logic separate_output_oe,
	// New conversion word from the converter core.
	input wire logic [23:0] result_data,
	input wire logic result_load,
	// Register contents toward the converter core.
	output logic [23:0] conversion_result,
	output logic [23:0] control_reg,
	output logic [23:0] offset_cal,
	output logic [23:0] pos_fullscale_cal,
	output logic [23:0] neg_fullscale_cal
);

	// Synchronised pins and edge pulses.
	logic [`ASCP_SYNC_W-1:0] pins_sync;
	logic sclk_rise;
	logic sclk_fall;
	// Cycle state.
	ascp_pkg::ascp_phase_t phase;
	logic [7:0] transfer_instruction;
	logic [7:0] shift_in;
	logic [2:0] bit_cnt;
	logic [1:0] bytes_left;
	logic [1:0] byte_idx;
	logic read_out_bit;

	ascp_pin_sync u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pins_raw({sdio_in, cs_n, sclk}),
		.pins_sync(pins_sync),
		.sclk_rise(sclk_rise),
		.sclk_fall(sclk_fall)
	);

	// Returns one byte of a 24-bit register; byte three addresses nothing.
	function automatic logic [7:0] pick_byte(input logic [23:0] word, input logic [1:0] idx);
		logic [7:0] b;
		b = `ASCP_UNDEF_BYTE;
		if (idx != `ASCP_BYTE_NONE) begin
			b = word[idx*8 +: 8];
		end
		return b;
	endfunction

	// Chip select active; edges while it is high are ignored so the cycle waits.
	wire cs_active = ~pins_sync[ascp_pkg::ASCP_PIN_CS_N];
	wire data_bit = pins_sync[ascp_pkg::ASCP_PIN_SDIO];
	wire rise_ok = sclk_rise & cs_active;
	wire fall_ok = sclk_fall & cs_active;
	wire byte_end = rise_ok & (bit_cnt == `ASCP_LAST_BIT);

	// Control fields steering the port.
	wire three_wire = control_reg[`ASCP_CTRL_LINE_USAGE];
	wire lsb_first = control_reg[`ASCP_CTRL_BIT_ORDER];
	wire ascending = control_reg[`ASCP_CTRL_BYTE_ORDER];

	// Stored instruction fields.
	wire is_write = transfer_instruction[`ASCP_INS_DIR_BIT];
	wire neg_select = transfer_instruction[`ASCP_INS_FSC_BIT];
	wire [1:0] reg_sel = transfer_instruction[`ASCP_INS_REG_HI:`ASCP_INS_REG_LO];

	// Incoming byte once the current bit lands; order follows control bit one.
	// Instruction bytes always shift in most significant bit first, whatever control bit one says.
	wire shift_lsb = lsb_first & (phase == ascp_pkg::ASCP_DATA);
	wire [7:0] next_shift = shift_lsb ? {data_bit, shift_in[7:1]} : {shift_in[6:0], data_bit};

	// Byte index after the current one, stepping up or down.
	wire [1:0] next_byte_idx = ascending ? 2'(byte_idx + 2'h1) : 2'(byte_idx - 2'h1);

	// Register word selected by the stored instruction.
	wire [23:0] fullscale_word = neg_select ? neg_fullscale_cal : pos_fullscale_cal;
	wire [23:0] sel_word = (reg_sel == `ASCP_SEL_RESULT) ? conversion_result :
		(reg_sel == `ASCP_SEL_CTRL) ? control_reg :
		(reg_sel == `ASCP_SEL_OFFSET) ? offset_cal : fullscale_word;
	wire [7:0] read_byte = pick_byte(sel_word, byte_idx);
	wire [2:0] out_pos = lsb_first ? bit_cnt : 3'(`ASCP_LAST_BIT - bit_cnt);

	// Write strobe for the target byte, never for the result register.
	wire wr_byte = (phase == ascp_pkg::ASCP_DATA) & is_write & byte_end & (byte_idx != `ASCP_BYTE_NONE);
	wire wr_ctrl = wr_byte & (reg_sel == `ASCP_SEL_CTRL);
	wire wr_off = wr_byte & (reg_sel == `ASCP_SEL_OFFSET);
	wire wr_pos = wr_byte & (reg_sel == `ASCP_SEL_FULLSCALE) & ~neg_select;
	wire wr_neg = wr_byte & (reg_sel == `ASCP_SEL_FULLSCALE) & neg_select;

	// A read of the result is under way; a new word must not tear it.
	wire result_busy = (phase == ascp_pkg::ASCP_DATA) & ~is_write & (reg_sel == `ASCP_SEL_RESULT);

	// Output enables: read phase with select low, line chosen by control bit zero.
	wire reading = (phase == ascp_pkg::ASCP_DATA) & ~is_write & cs_active;
	wire next_sdio_oe = reading & ~three_wire;
	wire next_sdo_oe = reading & three_wire;

	// Phase sequencing, instruction capture and byte counting on rising edges.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			phase <= ascp_pkg::ASCP_INSTR;
			transfer_instruction <= 8'h00;
			shift_in <= 8'h00;
			bit_cnt <= 3'h0;
			bytes_left <= 2'h0;
			byte_idx <= 2'h0;
		end else if (rise_ok) begin
			shift_in <= next_shift;
			bit_cnt <= 3'(bit_cnt + 3'h1);
			if (byte_end) begin
				unique case (phase)
					ascp_pkg::ASCP_INSTR: begin
						// Instruction bits always arrive first and most significant first.
						transfer_instruction <= {shift_in[6:0], data_bit};
						bytes_left <= shift_in[`ASCP_INS_CNT_HI-1:`ASCP_INS_CNT_LO-1];
						byte_idx <= {shift_in[`ASCP_INS_BYTE_HI-1:0], data_bit};
						phase <= ascp_pkg::ASCP_DATA;
					end
					ascp_pkg::ASCP_DATA: begin
						// Step to the next byte or return to waiting for an instruction.
						byte_idx <= next_byte_idx;
						bytes_left <= 2'(bytes_left - 2'h1);
						if (bytes_left == 2'h0) begin
							phase <= ascp_pkg::ASCP_INSTR;
						end
					end
				endcase
			end
		end
	end

	// Read bit launch on the falling edge of the serial clock.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			read_out_bit <= 1'b0;
		end else if (fall_ok & (phase == ascp_pkg::ASCP_DATA) & ~is_write) begin
			read_out_bit <= read_byte[out_pos];
		end
	end

	// Pin drivers, all registered.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sdio_oe <= 1'b0;
			separate_output_oe <= 1'b0;
		end else begin
			sdio_oe <= next_sdio_oe;
			separate_output_oe <= next_sdo_oe;
		end
	end
	assign sdio_out = read_out_bit;
	assign separate_output_line = read_out_bit;

	// Writable registers take a whole byte at its eighth bit.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			control_reg <= `ASCP_CTRL_RESET;
			offset_cal <= `ASCP_CAL_RESET;
			pos_fullscale_cal <= `ASCP_CAL_RESET;
			neg_fullscale_cal <= `ASCP_CAL_RESET;
		end else begin
			if (wr_ctrl) begin
				control_reg[byte_idx*8 +: 8] <= next_shift;
			end
			if (wr_off) begin
				offset_cal[byte_idx*8 +: 8] <= next_shift;
			end
			if (wr_pos) begin
				pos_fullscale_cal[byte_idx*8 +: 8] <= next_shift;
			end
			if (wr_neg) begin
				neg_fullscale_cal[byte_idx*8 +: 8] <= next_shift;
			end
		end
	end

	// Result register loads only from the converter, held while being read.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			conversion_result <= `ASCP_RESULT_RESET;
		end else if (result_load & ~result_busy) begin
			conversion_result <= result_data;
		end
	end

	default clocking ascp_cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// Last rising edge of an instruction byte.
	sequence s_instr_end;
		byte_end && phase == ascp_pkg::ASCP_INSTR;
	endsequence

	// Last rising edge of a data byte.
	sequence s_data_end;
		byte_end && phase == ascp_pkg::ASCP_DATA;
	endsequence

	AST_DIR_DECODE: assert property (phase == ascp_pkg::ASCP_DATA && is_write |=> !sdio_oe && !separate_output_oe)
		else $error("a line was driven during a write phase");
	AST_DIR_STORED: assert property (s_instr_end |=> phase == ascp_pkg::ASCP_DATA && is_write == $past(shift_in[6]))
		else $error("stored direction differs from captured bit");
	AST_COUNT: assert property (s_instr_end |=> bytes_left == $past(shift_in[5:4]))
		else $error("byte count field not loaded");
	AST_START_BYTE: assert property (s_instr_end |=> byte_idx == {$past(shift_in[0]), $past(data_bit)})
		else $error("starting byte not loaded");
	AST_RESULT_RO: assert property ($changed(conversion_result) |-> $past(result_load) && !$past(result_busy))
		else $error("result register changed without a converter load");
	AST_THREE_WIRE: assert property (separate_output_oe |-> $past(three_wire) && !sdio_oe)
		else $error("separate output driven outside three-wire mode");
	AST_TWO_WIRE: assert property (sdio_oe |-> !$past(three_wire) && !$past(is_write))
		else $error("data line driven outside a two-wire read");
	AST_LAUNCH: assert property ($changed(read_out_bit) |-> $past(sclk_fall))
		else $error("read bit changed away from a falling edge");
	AST_ASCEND: assert property (s_data_end ##0 ascending |=> byte_idx == 2'($past(byte_idx) + 2'h1))
		else $error("ascending byte step wrong");
	AST_LAST_BYTE: assert property (s_data_end ##0 (bytes_left == 2'h0) |=> phase == ascp_pkg::ASCP_INSTR)
		else $error("cycle did not end after the last byte");
	AST_SUSPEND: assert property (!cs_active |=> $stable(bit_cnt) && $stable(phase) && $stable(byte_idx))
		else $error("cycle advanced while select was high");
	AST_NO_BYTE3: assert property (phase == ascp_pkg::ASCP_DATA && byte_idx == 2'h3 |=> $stable(control_reg))
		else $error("write through unaddressed byte changed control");

	// Select is high, so serial clock edges must be ignored.
	sequence s_deselected;
		!cs_active;
	endsequence

	// A qualified falling edge inside a read phase.
	sequence s_read_fall;
		fall_ok && phase == ascp_pkg::ASCP_DATA && !is_write;
	endsequence

	// The incoming shifter only moves on a qualified rising edge.
	AST_CAPTURE_RISE: assert property ($changed(shift_in) |-> $past(rise_ok))
		else $error("incoming shifter moved away from a rising edge");

	// Both outputs are released one cycle after select is seen high.
	AST_RELEASE: assert property (s_deselected |=> !sdio_oe && !separate_output_oe)
		else $error("output still driven while deselected");

	// Descending order steps the byte index down by one.
	AST_DESCEND: assert property (s_data_end ##0 !ascending |=> byte_idx == 2'($past(byte_idx) - 2'h1))
		else $error("descending byte step wrong");

	// A byte that is not the last keeps the data phase and counts down.
	AST_COUNT_STEP: assert property (s_data_end ##0 (bytes_left != 2'h0) |=>
		phase == ascp_pkg::ASCP_DATA && bytes_left == 2'($past(bytes_left) - 2'h1))
		else $error("byte count did not step down");

	// Control changes only through a serial write aimed at it.
	AST_CTRL_TARGET: assert property ($changed(control_reg) |-> $past(wr_byte) && $past(reg_sel) == `ASCP_SEL_CTRL)
		else $error("control changed without a write to it");

	// Offset calibration changes only through a serial write aimed at it.
	AST_OFFSET_TARGET: assert property ($changed(offset_cal) |-> $past(wr_byte) && $past(reg_sel) == `ASCP_SEL_OFFSET)
		else $error("offset changed without a write to it");

	// Positive full scale changes only with the polarity bit clear.
	AST_POS_TARGET: assert property ($changed(pos_fullscale_cal) |->
		$past(wr_byte) && !$past(neg_select) && $past(reg_sel) == `ASCP_SEL_FULLSCALE)
		else $error("positive full scale changed by a foreign write");

	// Negative full scale changes only with the polarity bit set.
	AST_NEG_TARGET: assert property ($changed(neg_fullscale_cal) |->
		$past(wr_byte) && $past(neg_select) && $past(reg_sel) == `ASCP_SEL_FULLSCALE)
		else $error("negative full scale changed by a foreign write");

	// A launch edge never advances the bit counter.
	AST_FALL_NO_COUNT: assert property (s_read_fall |=> $stable(bit_cnt))
		else $error("bit counter moved on a falling edge");

endmodule // ascp_port

`default_nettype wire

// ### bench/ascp_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// Host side of the serial port: clocks, selects and moves bytes.
module ascp_host_model (
	// Pacing clock.
	input wire logic sys_clk,
	// Pins toward the port.
	output logic sclk,
	output logic cs_n,
	output logic sdio_in,
	// Pins from the port.
	input wire logic sdio_out,
	input wire logic sdio_oe,
	input wire logic separate_output_line,
	input wire logic separate_output_oe
);
	logic host_en; // High while the host drives the shared line.
	logic host_bit; // Bit the host puts on the shared line.
	// A released line shows the inverse of the last bit, never a stale copy.
	assign sdio_in = sdio_oe ? sdio_out : (host_en ? host_bit : ~host_bit);
	// Serial clock starts low and select idles high.
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		host_en = 1'b0;
		host_bit = 1'b0;
	end
	// Low half, rise, then high half; returns line and both enables at the rise.
	// The host takes or leaves the shared line at the fall, away from the capture edge.
	task automatic tick(output logic [2:0] smp, input logic sep, input logic drv);
		@(negedge sys_clk);
		sclk = 1'b0;
		host_en = drv;
		repeat (8) @(negedge sys_clk);
		sclk = 1'b1;
		smp = {sep ? separate_output_line : sdio_in, sdio_oe, separate_output_oe};
		repeat (7) @(negedge sys_clk);
	endtask
	// Select changes with the clock held where the last tick left it, high after any tick, then settles.
	task automatic sel(input logic v);
		@(negedge sys_clk);
		cs_n = v;
		if (v) begin
			host_en = 1'b0;
		end
		repeat (8) @(negedge sys_clk);
	endtask
	// Sends one byte on the shared line, each bit changed one system clock before the clock is driven low.
	task automatic put_byte(input logic [7:0] b, input logic lsb);
		logic [2:0] s;
		for (int i = 0; i < 8; i++) begin
			host_bit = lsb ? b[i] : b[7-i];
			tick(s, 1'b0, 1'b1);
		end
	endtask
	// Receives one byte; ok drops if the wrong output is enabled at a rise.
	task automatic get_byte(output logic [7:0] b, output logic ok, input logic lsb, input logic sep);
		logic [2:0] s;
		ok = 1'b1;
		for (int i = 0; i < 8; i++) begin
			tick(s, sep, 1'b0);
			b[lsb ? i : 7-i] = s[2];
			if (s[1:0] !== {!sep, sep}) begin
				ok = 1'b0;
			end
		end
	endtask
endmodule // ascp_host_model
`default_nettype wire

// ### bench/ascp_port_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

// Drives the port through the host model and checks register effects.
module ascp_port_tb_top;
	logic sys_clk, rst, sclk, cs_n, sdio_in, sdio_out, sdio_oe;
	logic separate_output_line, separate_output_oe, result_load;
	logic [23:0] result_data, conversion_result, control_reg, offset_cal, pos_fullscale_cal, neg_fullscale_cal;
	logic lsb_mode; // Expected bit order of data bytes.
	logic sep_mode; // Expected read line, high for the separate output.
	logic [31:0] q; // Bytes read, first byte lowest.
	int miscompares;
	int checked;

	ascp_port i_ascp_port (.sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe(sdio_oe), .separate_output_line(separate_output_line),
		.separate_output_oe(separate_output_oe), .result_data(result_data), .result_load(result_load),
		.conversion_result(conversion_result), .control_reg(control_reg), .offset_cal(offset_cal),
		.pos_fullscale_cal(pos_fullscale_cal), .neg_fullscale_cal(neg_fullscale_cal));
	ascp_host_model i_ascp_host_model (.sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe(sdio_oe), .separate_output_line(separate_output_line),
		.separate_output_oe(separate_output_oe));

	// System clock of 10 ns.
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Counts a comparison and reports a mismatch.
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// One write cycle of n data bytes.
	task automatic wr(input logic [7:0] ins, input logic [31:0] d, input int n);
		i_ascp_host_model.sel(1'b0);
		i_ascp_host_model.put_byte(ins, 1'b0);
		for (int k = 0; k < n; k++) begin
			i_ascp_host_model.put_byte(d[8*k +: 8], lsb_mode);
		end
		i_ascp_host_model.sel(1'b1);
	endtask
	// One read cycle; brk lifts select after the first byte and checks the line is freed.
	task automatic rd(input logic [7:0] ins, input int n, input logic brk);
		logic [7:0] b;
		logic ok;
		q = '0;
		i_ascp_host_model.sel(1'b0);
		i_ascp_host_model.put_byte(ins, 1'b0);
		for (int k = 0; k < n; k++) begin
			i_ascp_host_model.get_byte(b, ok, lsb_mode, sep_mode);
			q[8*k +: 8] = b;
			chk({23'h0, ok}, 24'h00_0001, "read line enable");
			if (brk && k == 0) begin
				i_ascp_host_model.sel(1'b1);
				chk({22'h0, sdio_oe, separate_output_oe}, 24'h00_0000, "enable while deselected");
				@(negedge sys_clk);
				result_data = 24'h5A_0F3C;
				result_load = 1'b1;
				@(negedge sys_clk);
				result_load = 1'b0;
				i_ascp_host_model.sel(1'b0);
			end
		end
		i_ascp_host_model.sel(1'b1);
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic end_of_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Main sequence.
	initial begin
		miscompares = 0;
		checked = 0;
		rst = 1'b1;
		result_load = 1'b0;
		result_data = 24'hA5_C396;
		lsb_mode = 1'b0;
		sep_mode = 1'b0;
		repeat (20) @(negedge sys_clk);
		rst = 1'b0;
		repeat (5) @(negedge sys_clk);
		chk(control_reg, 24'h00_0100, "control reset");
		chk(offset_cal, 24'h00_0000, "offset reset");
		$display("reset test done");
		wr(8'hCA, 32'h0056_3412, 3);
		chk(offset_cal, 24'h12_3456, "offset write descending");
		wr(8'h8D, 32'h0000_00AB, 1);
		chk(pos_fullscale_cal, 24'h00_AB00, "positive full scale");
		wr(8'hFE, 32'h4433_2211, 4);
		chk(neg_fullscale_cal, 24'h11_2233, "negative full scale four bytes");
		chk(pos_fullscale_cal, 24'h00_AB00, "positive untouched");
		$display("write test done");
		@(negedge sys_clk);
		result_load = 1'b1;
		@(negedge sys_clk);
		result_load = 1'b0;
		wr(8'hA2, 32'h0000_FFFF, 2);
		chk(conversion_result, 24'hA5_C396, "result not writable");
		rd(8'h42, 3, 1'b1);
		chk(q[23:0], 24'h96_C3A5, "result read with pause");
		chk(conversion_result, 24'hA5_C396, "load dropped during result read");
		@(negedge sys_clk);
		result_load = 1'b1;
		@(negedge sys_clk);
		result_load = 1'b0;
		chk(conversion_result, 24'h5A_0F3C, "load after result read");
		rd(8'h07, 1, 1'b0);
		chk(q[23:0], 24'h00_0000, "dead byte read");
		$display("two wire test done");
		wr(8'h84, 32'h0000_0007, 1);
		chk(control_reg, 24'h00_0107, "control write");
		lsb_mode = 1'b1;
		sep_mode = 1'b1;
		rd(8'h48, 3, 1'b0);
		chk(q[23:0], 24'h12_3456, "offset read ascending lsb first");
		rd(8'h5C, 3, 1'b0);
		chk(q[23:0], 24'h11_2233, "negative full scale read");
		rd(8'h04, 1, 1'b0);
		chk(q[23:0], 24'h00_0007, "control read");
		wr(8'h8C, 32'h0000_005A, 1);
		chk(pos_fullscale_cal, 24'h00_AB5A, "three wire write lsb first");
		$display("three wire test done");
		end_of_test();
	end
endmodule // ascp_port_tb_top
`default_nettype wire
